// File: verilog/clcfg_defs.svh
// Purpose: Named constants for the closed-loop configuration word.
// Assumes: Included by its bare name from the package and design files.
// Notes: Rates are in mV/s, frequencies in kHz, lead angle in millidegrees.
`ifndef CLCFG_DEFS_SVH
`define CLCFG_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CLCFG_ADDR_W 8
`define CLCFG_OFFSET 8'h86
`define CLCFG_RESET 32'h0000_0000
`define CLCFG_IDLE_RDATA 32'h0000_0000

// ----------------------------------------------------------------------
// Decode constants
// ----------------------------------------------------------------------
`define RATE_W 25
`define FREQ_W 7
`define FREQ_FINE_BASE_KHZ 7'h05
`define FREQ_COARSE_BASE_KHZ 7'h19
`define FREQ_COARSE_STEP_KHZ 7'h05
`define FREQ_COARSE_FIRST 5'h10
`define FREQ_LAST_VALID 5'h1e
`define LEAD_STEP_MDEG 15'h0078
`define LEAD_W 16

`endif

// File: verilog/clcfg_pkg.sv
// Purpose: Types shared by the closed-loop configuration register files.
// Assumes: The defs header supplies the rate, frequency and lead widths; the raw field widths are coded in the struct.
// Notes: The word layout is a packed struct so no bit position is coded by hand.
`include "clcfg_defs.svh"

package clcfg_pkg;

  typedef enum logic [1:0] {
    COMM_FIXED_120 = 2'b00,
    COMM_VARIABLE = 2'b01,
    COMM_RSVD_2 = 2'b10,
    COMM_RSVD_3 = 2'b11
  } comm_style_t;

  typedef enum logic [1:0] {
    MOD_HIGH_SIDE = 2'b00,
    MOD_LOW_SIDE = 2'b01,
    MOD_MIXED = 2'b10,
    MOD_RSVD = 2'b11
  } modul_side_t;

  // Bit 31 down to bit 0 of the configuration word.
  typedef struct packed {
    logic parity;
    comm_style_t commutation_style;
    logic [4:0] loop_accel_rate;
    logic decel_source_select;
    logic [4:0] loop_decel_rate;
    logic [4:0] switching_freq_code;
    modul_side_t modulation_side;
    logic complementary;
    logic lead_sign;
    logic [7:0] lead_amount;
    logic spare;
  } cfg_word_t;

  // Decoded settings handed to the controller core.
  typedef struct packed {
    comm_style_t commutation;
    logic comm_reserved;
    logic [`RATE_W-1:0] accel_rate_mv;
    logic [`RATE_W-1:0] decel_rate_mv;
    logic [`FREQ_W-1:0] freq_khz;
    logic freq_valid;
    modul_side_t modulation;
    logic modul_reserved;
    logic complementary;
    logic signed [`LEAD_W-1:0] lead_mdeg;
  } drive_cfg_t;

endpackage

// File: verilog/rate_table.sv
// Purpose: Maps a five-bit ramp code to a rate in mV/s.
// Assumes: Purely combinational; the caller registers the result.
// Notes: Same table serves acceleration and deceleration.
`timescale 1ns/1ps
`default_nettype none
`include "clcfg_defs.svh"

module rate_table
(
  input wire logic [4:0] code,
  output logic [`RATE_W-1:0] rate_mv
);

  always_comb
  begin
    unique case (code)
      5'h00: rate_mv = 25'h0000005;
      5'h01: rate_mv = 25'h000000a;
      5'h02: rate_mv = 25'h0000019;
      5'h03: rate_mv = 25'h0000032;
      5'h04: rate_mv = 25'h0000064;
      5'h05: rate_mv = 25'h00000fa;
      5'h06: rate_mv = 25'h00001f4;
      5'h07: rate_mv = 25'h00003e8;
      5'h08: rate_mv = 25'h00009c4;
      5'h09: rate_mv = 25'h0001388;
      5'h0a: rate_mv = 25'h0001d4c;
      5'h0b: rate_mv = 25'h0002710;
      5'h0c: rate_mv = 25'h00030d4;
      5'h0d: rate_mv = 25'h0003a98;
      5'h0e: rate_mv = 25'h0004e20;
      5'h0f: rate_mv = 25'h0007530;
      5'h10: rate_mv = 25'h0009c40;
      5'h11: rate_mv = 25'h000c350;
      5'h12: rate_mv = 25'h000ea60;
      5'h13: rate_mv = 25'h00124f8;
      5'h14: rate_mv = 25'h00186a0;
      5'h15: rate_mv = 25'h001e848;
      5'h16: rate_mv = 25'h00249f0;
      5'h17: rate_mv = 25'h002ab98;
      5'h18: rate_mv = 25'h0030d40;
      5'h19: rate_mv = 25'h003d090;
      5'h1a: rate_mv = 25'h00493e0;
      5'h1b: rate_mv = 25'h0061a80;
      5'h1c: rate_mv = 25'h007a120;
      5'h1d: rate_mv = 25'h00b71b0;
      5'h1e: rate_mv = 25'h00f4240;
      5'h1f: rate_mv = 25'h1f3fc18;
    endcase
  end

endmodule
`default_nettype wire

// File: verilog/freq_table.sv
// Purpose: Maps the switching frequency code to kHz.
// Assumes: Purely combinational; the caller registers the result.
// Notes: The top code has no documented frequency and is flagged invalid.
`timescale 1ns/1ps
`default_nettype none
`include "clcfg_defs.svh"

module freq_table
(
  input wire logic [4:0] code,
  output logic [`FREQ_W-1:0] freq_khz,
  output logic valid
);

  logic [`FREQ_W-1:0] steps;

  always_comb
  begin
    steps = `FREQ_W'(code - `FREQ_COARSE_FIRST);
    valid = (code <= `FREQ_LAST_VALID);
    if (code < `FREQ_COARSE_FIRST)
    begin
      freq_khz = `FREQ_W'(`FREQ_FINE_BASE_KHZ + `FREQ_W'(code));
    end
    else if (valid)
    begin
      freq_khz = `FREQ_W'(`FREQ_COARSE_BASE_KHZ + `FREQ_W'(steps * `FREQ_COARSE_STEP_KHZ));
    end
    else
    begin
      freq_khz = '0;
    end
  end

endmodule
`default_nettype wire

// File: verilog/closed_loop_config_register.sv
// Purpose: One read/write configuration word for the closed-loop motor control,
//          with its fields decoded for the controller core.
// Assumes: Plain register port; read data valid the cycle after the read strobe.
// Notes: Decoded outputs follow the stored word by one clock.
//
// What this block does
// (R1) Commutation code 0 fixed 120 degrees, 1 variable 120-150, 2 and 3 reserved.
// (R2) Five-bit acceleration code picks a table rate, 0.005 to 32767 V/s.
// (R3) Deceleration uses its own code when source bit clear, acceleration code when set.
// (R4) Five-bit deceleration code uses the same rate table as acceleration.
// (R5) Frequency code: 5-20 kHz by 1, then 25 kHz upward by 5, to 95.
// (R6) Modulation code 0 high-side, 1 low-side, 2 mixed, 3 reserved.
// (R7) Switching style bit: clear single-ended, set complementary.
// (R8) Lead sign bit: clear negative lead, set positive lead.
// (R9) Lead angle in degrees is the eight-bit field times 0.12.
// (R10) Word sits at offset 86h and resets to all zeros.
// (R11) Reads return the last written value in every bit.
`timescale 1ns/1ps
`default_nettype none
`include "clcfg_defs.svh"

module closed_loop_config_register
  import clcfg_pkg::*;
#(
  parameter int ADDR_W = `CLCFG_ADDR_W
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output cfg_word_t closed_loop_config_word,
  output drive_cfg_t drive
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = (a == ADDR_W'(`CLCFG_OFFSET));
  endfunction

  logic wr_hit;
  logic rd_hit;

  assign wr_hit = wr_en && hit(addr);
  assign rd_hit = rd_en && hit(addr);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      closed_loop_config_word <= cfg_word_t'(`CLCFG_RESET); // see (R10)
    end
    else if (wr_hit)
    begin
      closed_loop_config_word <= cfg_word_t'(wdata); // see (R11)
    end
  end

  // Read data stands only in the cycle after the strobe; all else reads zero.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= `CLCFG_IDLE_RDATA;
    end
    else if (rd_hit)
    begin
      rdata <= closed_loop_config_word; // see (R11)
    end
    else
    begin
      rdata <= `CLCFG_IDLE_RDATA;
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  cfg_word_t w;
  logic [4:0] decel_code;
  logic [`RATE_W-1:0] accel_rate;
  logic [`RATE_W-1:0] decel_rate;
  logic [`FREQ_W-1:0] freq_khz;
  logic freq_valid;
  logic [14:0] lead_mag;
  logic signed [`LEAD_W-1:0] lead_signed;

  assign w = closed_loop_config_word;
  // see (R3)
  assign decel_code = w.decel_source_select ? w.loop_accel_rate : w.loop_decel_rate;
  assign lead_mag = 15'(w.lead_amount * `LEAD_STEP_MDEG); // see (R9)
  // see (R8)
  assign lead_signed = w.lead_sign ? $signed({1'b0, lead_mag}) : -$signed({1'b0, lead_mag});

  rate_table u_accel_table
  (
    .code(w.loop_accel_rate),
    .rate_mv(accel_rate)
  );

  rate_table u_decel_table
  (
    .code(decel_code),
    .rate_mv(decel_rate)
  );

  freq_table u_freq_table
  (
    .code(w.switching_freq_code),
    .freq_khz(freq_khz),
    .valid(freq_valid)
  );

  // ----------------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drive.commutation <= COMM_FIXED_120;
      drive.comm_reserved <= 1'b0;
      drive.modulation <= MOD_HIGH_SIDE;
      drive.modul_reserved <= 1'b0;
      drive.complementary <= 1'b0;
    end
    else
    begin
      drive.commutation <= w.commutation_style; // see (R1)
      drive.comm_reserved <= (w.commutation_style inside {COMM_RSVD_2, COMM_RSVD_3});
      drive.modulation <= w.modulation_side; // see (R6)
      drive.modul_reserved <= (w.modulation_side == MOD_RSVD);
      drive.complementary <= w.complementary; // see (R7)
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drive.accel_rate_mv <= '0;
      drive.decel_rate_mv <= '0;
    end
    else
    begin
      drive.accel_rate_mv <= accel_rate; // see (R2)
      drive.decel_rate_mv <= decel_rate; // see (R4)
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      drive.freq_khz <= '0;
      drive.freq_valid <= 1'b0;
      drive.lead_mdeg <= '0;
    end
    else
    begin
      drive.freq_khz <= freq_khz; // see (R5)
      drive.freq_valid <= freq_valid;
      drive.lead_mdeg <= lead_signed; // see (R9)
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic written;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      written <= 1'b0;
    end
    else if (wr_hit)
    begin
      written <= 1'b1;
    end
  end

  property p_reset_zero;
    !written |-> closed_loop_config_word == cfg_word_t'(`CLCFG_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // see (R10)
    else $error("config word not zero before first write");

  property p_readback;
    wr_hit ##1 (rd_hit && !wr_en) |=> rdata == $past(wdata, 2);
  endproperty
  a_readback: assert property (p_readback) // see (R11)
    else $error("read did not return last written word");

  property p_unmapped_zero;
    (rd_en && !hit(addr)) |=> rdata == `CLCFG_IDLE_RDATA;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // see (R10)
    else $error("unmapped read returned nonzero data");

  property p_write_lands;
    wr_hit |=> closed_loop_config_word == cfg_word_t'($past(wdata));
  endproperty
  a_write_lands: assert property (p_write_lands) // see (R11)
    else $error("write did not land in config word");

  property p_foreign_write;
    (wr_en && !hit(addr)) |=> $stable(closed_loop_config_word);
  endproperty
  a_foreign_write: assert property (p_foreign_write) // see (R10)
    else $error("unmapped write changed config word");

  property p_idle_rdata;
    !rd_hit |=> rdata == `CLCFG_IDLE_RDATA;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) // see (R11)
    else $error("read data not zero outside a read");

  property p_comm;
    ##1 (drive.commutation == $past(w.commutation_style))
      && (drive.comm_reserved == $past(w.commutation_style[1]));
  endproperty
  a_comm: assert property (p_comm) // see (R1)
    else $error("commutation decode wrong");

  // Decoded outputs hold zeros through the release edge, so these wait for a sampled high reset.
  property p_accel_ends;
    arst_n && (w.loop_accel_rate == 5'h00) |=> drive.accel_rate_mv == 25'h0000005;
  endproperty
  a_accel_ends: assert property (p_accel_ends) // see (R2)
    else $error("accel code 0 not 5 mV/s");

  property p_accel_top;
    (w.loop_accel_rate == 5'h1f) |=> drive.accel_rate_mv == 25'h1f3fc18;
  endproperty
  a_accel_top: assert property (p_accel_top) // see (R2)
    else $error("accel top code not 32767 V/s");

  property p_decel_follow;
    w.decel_source_select |=> drive.decel_rate_mv == drive.accel_rate_mv;
  endproperty
  a_decel_follow: assert property (p_decel_follow) // see (R3)
    else $error("decel does not follow accel when source set");

  property p_decel_own;
    (!w.decel_source_select && w.loop_decel_rate == 5'h00 && w.loop_accel_rate != 5'h00)
      |=> drive.decel_rate_mv == 25'h0000005 && drive.decel_rate_mv != drive.accel_rate_mv;
  endproperty
  a_decel_own: assert property (p_decel_own) // see (R4)
    else $error("decel not using its own code");

  property p_freq_fine;
    arst_n && (w.switching_freq_code < 5'h10)
      |=> drive.freq_khz == 7'(7'h05 + $past(w.switching_freq_code)) && drive.freq_valid;
  endproperty
  a_freq_fine: assert property (p_freq_fine) // see (R5)
    else $error("fine frequency decode wrong");

  property p_freq_top;
    (w.switching_freq_code == 5'h1e) |=> drive.freq_khz == 7'h5f;
  endproperty
  a_freq_top: assert property (p_freq_top) // see (R5)
    else $error("frequency code 1Eh not 95 kHz");

  property p_modul;
    ##1 (drive.modulation == $past(w.modulation_side))
      && (drive.modul_reserved == ($past(w.modulation_side) == MOD_RSVD));
  endproperty
  a_modul: assert property (p_modul) // see (R6)
    else $error("modulation decode wrong");

  property p_style;
    ##1 drive.complementary == $past(w.complementary);
  endproperty
  a_style: assert property (p_style) // see (R7)
    else $error("switching style not applied");

  property p_lead_sign;
    (w.lead_amount != 8'h00) |=> (drive.lead_mdeg > 0) == $past(w.lead_sign);
  endproperty
  a_lead_sign: assert property (p_lead_sign) // see (R8)
    else $error("lead sign wrong");

  property p_lead_max;
    (w.lead_amount == 8'hff && w.lead_sign) |=> drive.lead_mdeg == 16'sh7788;
  endproperty
  a_lead_max: assert property (p_lead_max) // see (R9)
    else $error("lead magnitude wrong");

  c_write_read: cover property (wr_hit ##1 rd_hit);
  c_decel_follow: cover property (w.decel_source_select && w.loop_accel_rate != w.loop_decel_rate);
  c_freq_invalid: cover property (w.switching_freq_code == 5'h1f);
  c_comm_variable: cover property (drive.commutation == COMM_VARIABLE);

endmodule
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the closed-loop configuration register.
// Assumes: Register port with read data in the cycle after the read strobe.
// Notes: Drivers queue expected results; a monitor compares them on the falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "clcfg_defs.svh"

module testbench
  import clcfg_pkg::*;
;
  localparam logic [7:0] cfg_addr = 8'h86;
  localparam int rate_tbl[32] = '{5, 10, 25, 50, 100, 250, 500, 1000, 2500, 5000, 7500,
    10000, 12500, 15000, 20000, 30000, 40000, 50000, 60000, 75000, 100000, 125000,
    150000, 175000, 200000, 250000, 300000, 400000, 500000, 750000, 1000000, 32767000};

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  cfg_word_t closed_loop_config_word;
  drive_cfg_t drive;
  logic [31:0] model = 32'h0000_0000;
  logic [31:0] rq[$];
  logic [31:0] wq[$];
  logic [31:0] dq[$];
  int bad_count = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  closed_loop_config_register #(.ADDR_W(8)) closed_loop_config_register_inst
  (
    .clk(clk),
    .arst_n(arst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .closed_loop_config_word(closed_loop_config_word),
    .drive(drive)
  );

  // ----------------------------------------------------------------------
  // Expected decode of a stored word
  // ----------------------------------------------------------------------
  function automatic drive_cfg_t decode(input logic [31:0] w);
    cfg_word_t c;
    drive_cfg_t d;
    logic signed [15:0] m;
    c = w;
    m = 16'(c.lead_amount) * 16'h0078;
    d.commutation = c.commutation_style;
    d.comm_reserved = c.commutation_style[1];
    d.accel_rate_mv = `RATE_W'(rate_tbl[c.loop_accel_rate]);
    d.decel_rate_mv = `RATE_W'(rate_tbl[c.decel_source_select ? c.loop_accel_rate
                                                               : c.loop_decel_rate]);
    if (c.switching_freq_code < 5'h10)
      d.freq_khz = 7'(c.switching_freq_code) + 7'h05;
    else
      d.freq_khz = 7'(c.switching_freq_code - 5'h10) * 7'h05 + 7'h19;
    d.freq_valid = (c.switching_freq_code != 5'h1f);
    if (!d.freq_valid)
      d.freq_khz = 7'h00;
    d.modulation = c.modulation_side;
    d.modul_reserved = (c.modulation_side == MOD_RSVD);
    d.complementary = c.complementary;
    d.lead_mdeg = c.lead_sign ? m : -m;
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // Comparison, bus driver and closing
  // ----------------------------------------------------------------------
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic rd, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= rd;
    if (wr && a == cfg_addr)
      model = d;
    if (wr)
    begin
      wq.push_back(model);
      dq.push_back(model);
    end
    if (rd)
      rq.push_back((a == cfg_addr) ? model : 32'h0000_0000);
  endtask

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    check(closed_loop_config_word, 32'h0000_0000);
    check(drive, 128'h0);
    model = 32'h0000_0000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(negedge clk);
    check(drive, decode(32'h0000_0000));
    $display("test reset done");
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Monitor: takes the oldest note whenever a result is due
  // ----------------------------------------------------------------------
  initial
  begin
    logic rd_d1;
    logic wr_d1;
    logic wr_d2;
    rd_d1 = 1'b0;
    wr_d1 = 1'b0;
    wr_d2 = 1'b0;
    forever
    begin
      @(negedge clk);
      if (rd_d1)
        check(rdata, rq.pop_front());
      else
        check(rdata, 32'h0000_0000);
      if (wr_d1)
        check(closed_loop_config_word, wq.pop_front());
      if (wr_d2)
        check(drive, decode(dq.pop_front()));
      wr_d2 = wr_d1;
      wr_d1 = wr_en;
      rd_d1 = rd_en;
    end
  end

  initial
  begin
    #20000;
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    cfg_word_t c;
    logic [4:0] k;
    int op;
    void'($urandom(21));
    do_reset();
    bus(1'b0, 1'b1, cfg_addr, 32'h0000_0000);

    // Every code of every field except lead_amount, parity and spare (random), each write read straight back.
    // The last code pairs its own decel code 0 with a nonzero accel code.
    for (int i = 0; i < 32; i++)
    begin
      k = 5'(i);
      c = cfg_word_t'($urandom);
      c.commutation_style = comm_style_t'(k[1:0]);
      c.loop_accel_rate = k;
      c.decel_source_select = k[2] ^ k[0];
      c.loop_decel_rate = 5'h1f - k;
      c.switching_freq_code = k;
      c.modulation_side = modul_side_t'(k[1:0]);
      c.complementary = k[0];
      c.lead_sign = k[3];
      if (k == 5'h1f)
        c.lead_amount = 8'hff;
      bus(1'b1, 1'b0, cfg_addr, c);
      bus(1'b0, 1'b1, cfg_addr, 32'h0000_0000);
    end
    $display("test field_codes done");

    // Random mix of writes, reads and idles, some at unmapped addresses.
    for (int i = 0; i < 80; i++)
    begin
      op = $urandom % 3;
      k = 5'($urandom);
      bus(op == 0, op == 1, (k < 5'h08) ? 8'($urandom) : cfg_addr, $urandom);
    end
    bus(1'b1, 1'b0, 8'h87, 32'hffff_ffff);
    bus(1'b0, 1'b1, 8'h84, 32'h0000_0000);
    bus(1'b0, 1'b1, cfg_addr, 32'h0000_0000);
    bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    repeat (3) @(negedge clk);
    $display("test random_traffic done");

    do_reset();
    bus(1'b0, 1'b1, cfg_addr, 32'h0000_0000);
    bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
    repeat (4) @(negedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
